// *** acmc_checker.sv ***
// Port-level checks for the microphone converter control block.
// Assumes it is bound into acmc_top and shares its one clock and reset.
`timescale 1ns/1ps
module acmc_checker (
   input wire logic                         pclk,
   input wire logic                         presetn,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [31:0]                  paddr,
   input wire logic [31:0]                  pwdata,
   input wire logic [31:0]                  prdata,
   input wire logic                         adc_done,
   input wire logic                         touch_panel_req,
   input wire logic                         mic_adc_grant,
   input wire logic                         touch_panel_grant,
   input wire logic                         adc_ref_enable,
   input wire logic [acmc_pkg::RATE_W-1:0]  dac_rate_sel,
   input wire logic                         mic_page_stop_sel,
   input wire logic                         mic_block_enable,
   input wire logic                         mic_dma_valid
);
   import acmc_pkg::*;
   logic       wr_acc;
   logic       rd_acc;
   logic [2:0] wd_rate;
   logic       wd_ref;
   logic       wd_page;
   logic       wd_en;
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && penable && !pwrite;
   assign wd_rate = pwdata[2:0];
   assign wd_ref  = pwdata[BIT_REF_ENABLE];
   assign wd_page = pwdata[BIT_PAGE_STOP];
   assign wd_en   = pwdata[BIT_MIC_ENABLE];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // Register writes and reads
   // ---------------------------------------------------------------
   AST_DAC_RATE_WR: assert property (
      wr_acc && paddr == ADDR_DAC_RATE_CONFIG |=> dac_rate_sel == $past(wd_rate))
      else $error("speaker rate write lost");
   AST_REF_WR: assert property (
      wr_acc && paddr == ADDR_MIC_CONTROL |=> adc_ref_enable == $past(wd_ref))
      else $error("reference enable write lost");
   AST_PAGE_STOP_WR: assert property (
      wr_acc && paddr == ADDR_MIC_CONTROL |=> mic_page_stop_sel == $past(wd_page))
      else $error("page stop write lost");
   AST_ENABLE_WR: assert property (
      wr_acc && paddr == ADDR_UNIT_SEQ_CONTROL |=> mic_block_enable == $past(wd_en))
      else $error("block enable write lost");
   AST_CTRL_READ: assert property (
      rd_acc && paddr == ADDR_MIC_CONTROL |-> prdata[BIT_RUN_STATE] == mic_block_enable
      && prdata[15] == adc_ref_enable && prdata[1] == mic_page_stop_sel
      && prdata[31:16] == 16'h0 && prdata[14:4] == 11'h0 && prdata[2] == 1'b0)
      else $error("control read wrong");
   AST_RATE_READ: assert property (
      rd_acc && (paddr == ADDR_DAC_RATE_CONFIG || paddr == ADDR_ADC_RATE_CONFIG)
      |-> prdata[31:3] == 29'h0)
      else $error("rate read has reserved bits set");
   // ---------------------------------------------------------------
   // Converter arbitration and sample path
   // ---------------------------------------------------------------
   AST_MIC_PRIORITY: assert property (
      touch_panel_grant == (touch_panel_req && !mic_adc_grant))
      else $error("touch panel grant wrong");
   AST_NO_GRANT_OFF: assert property (
      !mic_block_enable |-> !mic_adc_grant)
      else $error("grant while disabled");
   AST_SAMPLE_HOLD: assert property (
      adc_done && mic_adc_grant |=> !mic_adc_grant ##1 (mic_dma_valid || !mic_block_enable))
      else $error("sample not held or forwarded");
   AST_FLUSH: assert property (
      $fell(mic_block_enable) |=> !mic_dma_valid)
      else $error("queue not flushed on disable");
   COV_FILL: cover property (mic_dma_valid && !mic_adc_grant && mic_block_enable);
   COV_PRIORITY: cover property (touch_panel_req && mic_adc_grant);
   COV_FLUSH: cover property ($fell(mic_block_enable) && mic_dma_valid);
endmodule : acmc_checker

bind acmc_top acmc_checker i_checker (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .adc_done,
   .touch_panel_req, .mic_adc_grant, .touch_panel_grant, .adc_ref_enable, .dac_rate_sel,
   .mic_page_stop_sel, .mic_block_enable, .mic_dma_valid
);

// *** acmc_conv_model.sv ***
// Behavioural A/D converter and DMA consumer facing the microphone block.
// Assumes one shared clock; run, stall and delay come from the bench.
`timescale 1ns/1ps
module acmc_conv_model (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          run,
   input  wire logic                          stall,
   input  wire logic [3:0]                    delay,
   input  wire logic                          mic_adc_grant,
   output logic                               adc_done,
   output logic      [acmc_pkg::SAMPLE_W-1:0] adc_data,
   output logic                               mic_dma_ready
);
   import acmc_pkg::*;
   logic [3:0]          cnt;
   logic [SAMPLE_W-1:0] seq;
   // ---------------------------------------------------------------
   // Conversion
   // ---------------------------------------------------------------
   // Between samples the data lines flip every cycle, so a sample latched
   // without the done strobe shows up as a wrong word.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt           <= 4'h0;
         seq           <= 10'h100;
         adc_done      <= 1'b0;
         adc_data      <= 10'h155;
         mic_dma_ready <= 1'b0;
      end else begin
         adc_done      <= 1'b0;
         adc_data      <= ~adc_data;
         mic_dma_ready <= !stall;
         if (run && mic_adc_grant && !adc_done) begin
            cnt <= cnt + 4'h1;
            if (cnt >= delay) begin
               cnt      <= 4'h0;
               adc_done <= 1'b1;
               adc_data <= seq;
               seq      <= seq + 10'h0C7;
            end
         end
      end
   end
endmodule : acmc_conv_model

// *** acmc_pkg.sv ***
// Package for the audio converter microphone control block: register map, fields, resets.
// Assumes a 32-bit APB master and one 16-bit register per aligned word.
package acmc_pkg;

   // ----------------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ----------------------------------------------------------------------
   localparam logic [31:0] IDX_DAC_RATE_CONFIG  = 32'h0B00016A;
   localparam logic [31:0] IDX_MIC_INPUT_SAMPLE = 32'h0B000170;
   localparam logic [31:0] IDX_MIC_CONTROL      = 32'h0B000172;
   localparam logic [31:0] IDX_ADC_RATE_CONFIG  = 32'h0B000174;
   localparam logic [31:0] IDX_UNIT_SEQ_CONTROL = 32'h0B00017A;

   localparam logic [31:0] ADDR_DAC_RATE_CONFIG  = {IDX_DAC_RATE_CONFIG[29:0], 2'b00};
   localparam logic [31:0] ADDR_MIC_INPUT_SAMPLE = {IDX_MIC_INPUT_SAMPLE[29:0], 2'b00};
   localparam logic [31:0] ADDR_MIC_CONTROL      = {IDX_MIC_CONTROL[29:0], 2'b00};
   localparam logic [31:0] ADDR_ADC_RATE_CONFIG  = {IDX_ADC_RATE_CONFIG[29:0], 2'b00};
   localparam logic [31:0] ADDR_UNIT_SEQ_CONTROL = {IDX_UNIT_SEQ_CONTROL[29:0], 2'b00};

   // ----------------------------------------------------------------------
   // Field positions and widths.
   // ----------------------------------------------------------------------
   localparam int RATE_W          = 3;
   localparam int SAMPLE_W        = 10;
   localparam int FIFO_DEPTH      = 8;
   localparam int BIT_REF_ENABLE  = 15;
   localparam int BIT_RUN_STATE   = 3;
   localparam int BIT_PAGE_STOP   = 1;
   localparam int BIT_USE_REQUEST = 0;
   localparam int BIT_MIC_ENABLE  = 4;

   // ----------------------------------------------------------------------
   // Reset values and rate codes.
   // ----------------------------------------------------------------------
   localparam logic [RATE_W-1:0]   RATE_RESET    = 3'h0;
   localparam logic [SAMPLE_W-1:0] SAMPLE_RESET  = 10'h200;
   localparam logic [RATE_W-1:0]   RATE_11K025   = 3'h0;
   localparam logic [RATE_W-1:0]   RATE_22K05    = 3'h1;
   localparam logic [RATE_W-1:0]   RATE_44K1     = 3'h2;
   localparam logic [RATE_W-1:0]   RATE_8K       = 3'h4;

   function automatic logic acmc_rate_ok(input logic [RATE_W-1:0] code);
      acmc_rate_ok = (code == RATE_11K025) || (code == RATE_22K05) ||
                     (code == RATE_44K1) || (code == RATE_8K);
   endfunction : acmc_rate_ok

endpackage : acmc_pkg

// *** acmc_top.sv ***
// Microphone converter control: APB registers, A/D arbitration, sample path and FIFO.
// Assumes the converters, the touch panel unit and the DMA engine sit outside on plain ports.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

// --------------------------------------------------------------------------
// Sample FIFO
// --------------------------------------------------------------------------
module acmc_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic [AW-1:0]    nxt_wr_ptr;
   logic [AW-1:0]    nxt_rd_ptr;
   logic [AW:0]      nxt_count;
   logic             push;
   logic             pop;

   assign in_ready  = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data  = mem_ff[rd_ptr_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_count  = count_ff;
      if (flush) begin
         nxt_wr_ptr = '0;
         nxt_rd_ptr = '0;
         nxt_count  = '0;
      end else begin
         if (push) begin
            nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            nxt_count = count_ff + 1'b1;
         end else if (pop && !push) begin
            nxt_count = count_ff - 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff  <= nxt_count;
      end
   end

   // The storage has no reset; a word is only read after it was written.
   always_ff @(posedge pclk) begin
      if (push && !flush) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

endmodule : acmc_fifo

// --------------------------------------------------------------------------
// Top level
// --------------------------------------------------------------------------
// Summary of operation
// - Speaker rate codes: 000,001,010,100; rest reserved.
// - Reserved bits ignored on write, read zero.
// - Ten-bit A/D sample, forwarded to DMA holding.
// - Sample writes accepted only while block enabled.
// - Disable forces sample to 0x200; same at reset.
// - Bit 15 connects A/D reference when set.
// - Run state bit 3 mirrors block enable.
// - Bit 1 selects one- or two-page DMA stop.
// - Microphone wins A/D over touch panel.
// - Microphone rate uses the speaker encoding.
// - Bit 4 enables microphone block and DMA.
module acmc_top (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [31:0]                    paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic                           adc_done,
   input  wire logic [acmc_pkg::SAMPLE_W-1:0]  adc_data,
   input  wire logic                           touch_panel_req,
   output logic                                mic_adc_grant,
   output logic                                touch_panel_grant,
   output logic                                adc_ref_enable,
   output logic      [acmc_pkg::RATE_W-1:0]    adc_rate_sel,
   output logic                                adc_rate_supported,
   output logic      [acmc_pkg::RATE_W-1:0]    dac_rate_sel,
   output logic                                dac_rate_supported,
   output logic                                mic_page_stop_sel,
   output logic                                mic_block_enable,
   output logic      [acmc_pkg::SAMPLE_W-1:0]  mic_dma_data,
   output logic                                mic_dma_valid,
   input  wire logic                           mic_dma_ready
);
   import acmc_pkg::*;

   // -----------------------------------------------------------------------
   // State
   // -----------------------------------------------------------------------
   logic [RATE_W-1:0]   dac_rate_ff;
   logic [RATE_W-1:0]   adc_rate_ff;
   logic [SAMPLE_W-1:0] sample_ff;
   logic                sample_full_ff;
   logic                ref_enable_ff;
   logic                page_stop_ff;
   logic                enable_ff;
   logic [31:0]         prdata_ff;
   logic                pslverr_ff;

   logic [RATE_W-1:0]   nxt_dac_rate;
   logic [RATE_W-1:0]   nxt_adc_rate;
   logic [SAMPLE_W-1:0] nxt_sample;
   logic                nxt_sample_full;
   logic                nxt_ref_enable;
   logic                nxt_page_stop;
   logic                nxt_enable;
   logic [31:0]         nxt_prdata;
   logic                nxt_pslverr;

   logic                setup_phase;
   logic                write_access;
   logic                hit_dac;
   logic                hit_sample;
   logic                hit_control;
   logic                hit_adc;
   logic                hit_seq;
   logic                mapped;
   logic                mic_req;
   logic                fifo_in_ready;
   logic [15:0]         control_view;

   // -----------------------------------------------------------------------
   // Decode and handshake
   // -----------------------------------------------------------------------
   assign setup_phase  = psel && !penable;
   assign write_access = psel && penable && pwrite;
   assign hit_dac      = (paddr == ADDR_DAC_RATE_CONFIG);
   assign hit_sample   = (paddr == ADDR_MIC_INPUT_SAMPLE);
   assign hit_control  = (paddr == ADDR_MIC_CONTROL);
   assign hit_adc      = (paddr == ADDR_ADC_RATE_CONFIG);
   assign hit_seq      = (paddr == ADDR_UNIT_SEQ_CONTROL);
   assign mapped       = hit_dac || hit_sample || hit_control || hit_adc || hit_seq;

   // Read data is captured in the setup cycle, so every access finishes without wait states.
   assign pready  = 1'b1;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;

   // -----------------------------------------------------------------------
   // Converter arbitration
   // -----------------------------------------------------------------------
   // The request drops while a sample waits for FIFO room, so a busy DMA engine
   // stalls conversions instead of losing samples.
   assign mic_req           = enable_ff && !sample_full_ff && acmc_rate_ok(adc_rate_ff);
   assign mic_adc_grant     = mic_req;
   assign touch_panel_grant = touch_panel_req && !mic_req;

   // -----------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------
   assign adc_ref_enable     = ref_enable_ff;
   assign adc_rate_sel       = adc_rate_ff;
   assign adc_rate_supported = acmc_rate_ok(adc_rate_ff);
   assign dac_rate_sel       = dac_rate_ff;
   assign dac_rate_supported = acmc_rate_ok(dac_rate_ff);
   assign mic_page_stop_sel  = page_stop_ff;
   assign mic_block_enable   = enable_ff;

   // Reserved positions are tied to zero in the read views.
   always_comb begin
      control_view                  = 16'h0000;
      control_view[BIT_REF_ENABLE]  = ref_enable_ff;
      control_view[BIT_RUN_STATE]   = enable_ff;
      control_view[BIT_PAGE_STOP]   = page_stop_ff;
      control_view[BIT_USE_REQUEST] = mic_req;
   end

   // -----------------------------------------------------------------------
   // Register and sample next state
   // -----------------------------------------------------------------------
   always_comb begin
      nxt_dac_rate    = dac_rate_ff;
      nxt_adc_rate    = adc_rate_ff;
      nxt_ref_enable  = ref_enable_ff;
      nxt_page_stop   = page_stop_ff;
      nxt_enable      = enable_ff;
      nxt_sample      = sample_ff;
      nxt_sample_full = sample_full_ff;
      nxt_prdata      = prdata_ff;
      nxt_pslverr     = pslverr_ff;

      if (setup_phase) begin
         nxt_pslverr = !mapped;
         nxt_prdata  = 32'h0000_0000;
         if (pwrite) begin
            nxt_prdata = 32'h0000_0000;
         end else if (hit_dac) begin
            nxt_prdata = {29'h0000_0000, dac_rate_ff};
         end else if (hit_sample) begin
            nxt_prdata = {22'h00_0000, sample_ff};
         end else if (hit_control) begin
            nxt_prdata = {16'h0000, control_view};
         end else if (hit_adc) begin
            nxt_prdata = {29'h0000_0000, adc_rate_ff};
         end else if (hit_seq) begin
            nxt_prdata = {27'h000_0000, enable_ff, 4'h0};
         end
      end

      // Only the documented bits are taken; everything else in pwdata is dropped.
      if (write_access) begin
         if (hit_dac) begin
            nxt_dac_rate = pwdata[RATE_W-1:0];
         end else if (hit_control) begin
            nxt_ref_enable = pwdata[BIT_REF_ENABLE];
            nxt_page_stop  = pwdata[BIT_PAGE_STOP];
         end else if (hit_adc) begin
            nxt_adc_rate = pwdata[RATE_W-1:0];
         end else if (hit_seq) begin
            nxt_enable = pwdata[BIT_MIC_ENABLE];
         end
      end

      if (!enable_ff) begin
         nxt_sample      = SAMPLE_RESET;
         nxt_sample_full = 1'b0;
      end else begin
         if (sample_full_ff && fifo_in_ready) begin
            nxt_sample_full = 1'b0;
         end
         if (write_access && hit_sample) begin
            nxt_sample      = pwdata[SAMPLE_W-1:0];
            nxt_sample_full = 1'b1;
         end
         if (adc_done && mic_adc_grant) begin
            nxt_sample      = adc_data;
            nxt_sample_full = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_rate_ff    <= RATE_RESET;
         adc_rate_ff    <= RATE_RESET;
         ref_enable_ff  <= 1'b0;
         page_stop_ff   <= 1'b0;
         enable_ff      <= 1'b0;
         sample_ff      <= SAMPLE_RESET;
         sample_full_ff <= 1'b0;
         prdata_ff      <= 32'h0000_0000;
         pslverr_ff     <= 1'b0;
      end else begin
         dac_rate_ff    <= nxt_dac_rate;
         adc_rate_ff    <= nxt_adc_rate;
         ref_enable_ff  <= nxt_ref_enable;
         page_stop_ff   <= nxt_page_stop;
         enable_ff      <= nxt_enable;
         sample_ff      <= nxt_sample;
         sample_full_ff <= nxt_sample_full;
         prdata_ff      <= nxt_prdata;
         pslverr_ff     <= nxt_pslverr;
      end
   end

   // -----------------------------------------------------------------------
   // Path toward the DMA holding register
   // -----------------------------------------------------------------------
   // Clearing the enable also stops DMA, so buffered samples are discarded.
   acmc_fifo #(
      .WIDTH (SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .flush     (!enable_ff),
      .in_valid  (sample_full_ff),
      .in_ready  (fifo_in_ready),
      .in_data   (sample_ff),
      .out_valid (mic_dma_valid),
      .out_ready (mic_dma_ready),
      .out_data  (mic_dma_data)
   );

endmodule : acmc_top

// *** acmc_top_tb.sv ***
// Self-checking bench for the microphone converter control block.
// Assumes the converter model and the bound checker are compiled before it.
`timescale 1ns/1ps
module acmc_top_tb;
   import acmc_pkg::*;
   typedef struct packed {logic [31:0] addr; logic [31:0] wdata; logic [31:0] exp;} acmc_row_t;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic                adc_done, run, stall, touch_panel_req, mic_adc_grant, touch_panel_grant;
   logic                adc_ref_enable, adc_rate_supported, dac_rate_supported;
   logic                mic_page_stop_sel, mic_block_enable, mic_dma_valid, mic_dma_ready;
   logic [3:0]          delay;
   logic [RATE_W-1:0]   adc_rate_sel, dac_rate_sel;
   logic [SAMPLE_W-1:0] adc_data, mic_dma_data, last_acc;
   logic [31:0]         paddr, pwdata, prdata, rd;
   logic [SAMPLE_W-1:0] exp_q [$];
   int                  fail_count, check_count, acc_n, pop_n, n;
   acmc_row_t rows [11] = '{
      '{ADDR_DAC_RATE_CONFIG, 32'h1, 32'h1}, '{ADDR_DAC_RATE_CONFIG, 32'h2, 32'h2},
      '{ADDR_DAC_RATE_CONFIG, 32'h4, 32'h4}, '{ADDR_DAC_RATE_CONFIG, 32'h0, 32'h0},
      '{ADDR_ADC_RATE_CONFIG, 32'h2, 32'h2}, '{ADDR_ADC_RATE_CONFIG, 32'h1, 32'h1},
      '{ADDR_ADC_RATE_CONFIG, 32'h0, 32'h0}, '{ADDR_ADC_RATE_CONFIG, 32'h4, 32'h4},
      '{ADDR_MIC_CONTROL, 32'h8002, 32'h8002}, '{ADDR_MIC_CONTROL, 32'h000B, 32'h0002},
      '{ADDR_MIC_INPUT_SAMPLE, 32'h0155, 32'h0200}};
   acmc_row_t rst_rows [5] = '{
      '{ADDR_DAC_RATE_CONFIG, 32'h0, 32'h0}, '{ADDR_MIC_INPUT_SAMPLE, 32'h0, 32'h0200},
      '{ADDR_MIC_CONTROL, 32'h0, 32'h0}, '{ADDR_ADC_RATE_CONFIG, 32'h0, 32'h0},
      '{ADDR_UNIT_SEQ_CONTROL, 32'h0, 32'h0}};

   acmc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .adc_done, .adc_data, .touch_panel_req, .mic_adc_grant,
      .touch_panel_grant, .adc_ref_enable, .adc_rate_sel, .adc_rate_supported, .dac_rate_sel,
      .dac_rate_supported, .mic_page_stop_sel, .mic_block_enable, .mic_dma_data,
      .mic_dma_valid, .mic_dma_ready);
   acmc_conv_model i_model (.pclk, .presetn, .run, .stall, .delay, .mic_adc_grant, .adc_done,
      .adc_data, .mic_dma_ready);

   // ---------------------------------------------------------------
   // Checking and reporting
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk1(input string what, input logic exp, input logic got);
      chk(what, {31'h0, exp}, {31'h0, got});
   endtask : chk1
   task automatic guard(input logic ok);
      if (!ok) begin
         fail_count++;
         $display("unexpected wait: bound used up");
         close_out();
      end
   endtask : guard
   // The master waits on pready with a bound rather than assuming zero wait states.
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      guard(n < 50);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic reset_dut();
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask : reset_dut

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Disabling the block drops everything queued, so the expectation goes too.
   always @(posedge pclk) begin
      if (presetn && !mic_block_enable) exp_q.delete();
      if (presetn && adc_done && mic_adc_grant) begin
         exp_q.push_back(adc_data);
         last_acc = adc_data;
         acc_n++;
      end
      if (presetn && mic_dma_valid && mic_dma_ready) begin
         pop_n++;
         chk("dma word", {22'h0, exp_q.size() > 0 ? exp_q.pop_front() : 10'hXXX},
             {22'h0, mic_dma_data});
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, run, stall, touch_panel_req} = '0;
      {paddr, pwdata, delay} = '0;
      reset_dut();
      for (int i = 0; i < 11; i++) begin
         apb(1'b1, rows[i].addr, rows[i].wdata);
         apb(1'b0, rows[i].addr, 32'h0);
         chk("register read", rows[i].exp, rd);
         chk1("register error", 1'b0, er);
      end
      chk1("rate codes", 1'b1, adc_rate_supported && dac_rate_supported);
      chk("rate pins", 32'h0000_0020, {26'h0, adc_rate_sel, dac_rate_sel});
      touch_panel_req <= 1'b1;
      apb(1'b1, ADDR_UNIT_SEQ_CONTROL, 32'h10);
      apb(1'b0, ADDR_MIC_CONTROL, 32'h0);
      chk("control enabled", 32'h000B, rd);
      chk1("touch grant", 1'b0, touch_panel_grant);
      apb(1'b1, ADDR_MIC_INPUT_SAMPLE, 32'h0155);
      exp_q.push_back(10'h155);
      apb(1'b0, ADDR_MIC_INPUT_SAMPLE, 32'h0);
      chk("debug sample", 32'h0155, rd);
      stall <= 1'b1;
      delay <= 4'h2;
      run   <= 1'b1;
      for (n = 0; acc_n < 9 && n < 400; n++) @(posedge pclk);
      guard(n < 400);
      repeat (5) @(posedge pclk);
      chk1("grant when full", 1'b0, mic_adc_grant);
      chk1("touch grant", 1'b1, touch_panel_grant);
      apb(1'b0, ADDR_MIC_CONTROL, 32'h0);
      chk("control full", 32'h000A, rd);
      apb(1'b0, ADDR_MIC_INPUT_SAMPLE, 32'h0);
      chk("held sample", {22'h0, last_acc}, rd);
      run   <= 1'b0;
      stall <= 1'b0;
      for (n = 0; (exp_q.size() != 0 || mic_dma_valid !== 1'b0) && n < 400; n++) @(posedge pclk);
      guard(n < 400);
      chk("words drained", 32'h0000_000A, pop_n);
      delay <= 4'h0;
      run   <= 1'b1;
      repeat (30) @(posedge pclk);
      stall <= 1'b1;
      repeat (12) @(posedge pclk);
      run <= 1'b0;
      apb(1'b1, ADDR_UNIT_SEQ_CONTROL, 32'h0);
      apb(1'b0, ADDR_MIC_INPUT_SAMPLE, 32'h0);
      chk("sample after disable", 32'h0200, rd);
      chk1("queue after disable", 1'b0, mic_dma_valid);
      stall <= 1'b0;
      apb(1'b0, ADDR_ADC_RATE_CONFIG + 32'h4, 32'h0);
      chk("unmapped read", 32'h0, rd);
      chk1("unmapped error", 1'b1, er);
      apb(1'b1, ADDR_DAC_RATE_CONFIG, 32'h2);
      reset_dut();
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, rst_rows[i].addr, 32'h0);
         chk("reset value", rst_rows[i].exp, rd);
      end
      close_out();
   end
endmodule : acmc_top_tb
